/* File: design/rgc_pkg.sv */
package rgc_pkg;

    // Seven-bit target address on the serial bus.
    localparam logic [6:0] RGC_TARGET_ADDR = 7'h68;

    // Register offsets reached through the serial pointer.
    localparam logic [7:0] RGC_OFS_LIN_ONE = 8'h02;
    localparam logic [7:0] RGC_OFS_LIN_TWO = 8'h03;
    localparam logic [7:0] RGC_OFS_BUCK_OPT = 8'h04;
    localparam logic [7:0] RGC_OFS_SYS_CTRL = 8'h05;
    localparam logic [7:0] RGC_OFS_SLEW = 8'h06;

    // Field positions inside the option, control and slew registers.
    localparam int RGC_POS_PHASE = 6;
    localparam int RGC_POS_ULTRA_TWO = 5;
    localparam int RGC_POS_ULTRA_ONE = 4;
    localparam int RGC_POS_DIS_TWO = 3;
    localparam int RGC_POS_DIS_ONE = 2;
    localparam int RGC_POS_AUTO_TWO = 1;
    localparam int RGC_POS_AUTO_ONE = 0;
    localparam int RGC_POS_BUS_EN = 6;
    localparam int RGC_POS_POR_LO = 4;
    localparam int RGC_POS_EN_LIN_TWO = 3;
    localparam int RGC_POS_EN_LIN_ONE = 2;
    localparam int RGC_POS_EN_BUCK_TWO = 1;
    localparam int RGC_POS_EN_BUCK_ONE = 0;
    localparam int RGC_POS_SLEW_TWO_LO = 5;
    localparam int RGC_POS_SLEW_ONE_LO = 1;

    // Linear regulator code: 0.90 V at code 00, 50 mV steps, 3.60 V at the top code.
    localparam logic [5:0] RGC_LIN_CODE_MAX = 6'h36;
    localparam logic [5:0] RGC_LIN_CODE_RST = 6'h0C;

    // Power-on delay settings in milliseconds, selected by the delay field.
    localparam int RGC_POR_MS_0 = 1;
    localparam int RGC_POR_MS_1 = 50;
    localparam int RGC_POR_MS_2 = 150;
    localparam int RGC_POR_MS_3 = 200;

    // Reset values of single fields.
    localparam logic RGC_PHASE_RST = 1'b0;
    localparam logic RGC_ULTRA_RST = 1'b0;
    localparam logic RGC_DIS_RST = 1'b1;
    localparam logic RGC_AUTO_RST = 1'b1;
    localparam logic RGC_BUS_EN_RST = 1'b0;
    localparam logic [1:0] RGC_POR_RST = 2'h2;
    localparam logic RGC_RAIL_EN_RST = 1'b1;
    localparam logic [2:0] RGC_SLEW_RST = 3'h1;

    // All control fields presented to the regulator cores.
    typedef struct packed {
        logic [5:0] linear_one_code;
        logic [5:0] linear_two_code;
        logic buck_phase_select;
        logic buck_two_ultrasonic;
        logic buck_one_ultrasonic;
        logic buck_two_discharge;
        logic buck_one_discharge;
        logic buck_two_auto_mode;
        logic buck_one_auto_mode;
        logic bus_function_enable;
        logic [1:0] power_on_delay_sel;
        logic linear_two_enable;
        logic linear_one_enable;
        logic buck_two_enable;
        logic buck_one_enable;
        logic [2:0] buck_two_slew_code;
        logic [2:0] buck_one_slew_code;
    } rgc_ctrl_t;

    localparam rgc_ctrl_t RGC_CTRL_RST = '{
        linear_one_code: RGC_LIN_CODE_RST,
        linear_two_code: RGC_LIN_CODE_RST,
        buck_phase_select: RGC_PHASE_RST,
        buck_two_ultrasonic: RGC_ULTRA_RST,
        buck_one_ultrasonic: RGC_ULTRA_RST,
        buck_two_discharge: RGC_DIS_RST,
        buck_one_discharge: RGC_DIS_RST,
        buck_two_auto_mode: RGC_AUTO_RST,
        buck_one_auto_mode: RGC_AUTO_RST,
        bus_function_enable: RGC_BUS_EN_RST,
        power_on_delay_sel: RGC_POR_RST,
        linear_two_enable: RGC_RAIL_EN_RST,
        linear_one_enable: RGC_RAIL_EN_RST,
        buck_two_enable: RGC_RAIL_EN_RST,
        buck_one_enable: RGC_RAIL_EN_RST,
        buck_two_slew_code: RGC_SLEW_RST,
        buck_one_slew_code: RGC_SLEW_RST
    };

    // Serial target states, one-hot.
    typedef enum logic [5:0] {
        RGC_ST_IDLE = 6'b000001,
        RGC_ST_ADDR = 6'b000010,
        RGC_ST_ACK = 6'b000100,
        RGC_ST_RX = 6'b001000,
        RGC_ST_TX = 6'b010000,
        RGC_ST_TXACK = 6'b100000
    } rgc_state_t;

endpackage

/* File: design/rgc_regs.sv */
`timescale 1ns/1ps

// Behaviour
// [R1] Two linear voltage registers, 6-bit code, offsets 02/03.
// [R2] Linear code: 0.90 V plus 50 mV steps.
// [R3] Linear voltage registers reset to code 0C.
// [R4] Option bit 6 selects buck phase relation.
// [R5] Option bits 5:4 enable ultrasonic light-load operation.
// [R6] Option bits 3:2 enable discharge, reset one.
// [R7] Option bits 1:0 choose auto or forced PWM.
// [R8] Control bit 6 is bus function enable.
// [R9] Control bits 5:4 select power-on delay.
// [R10] Control bits 3:0 enable the four rails.
// [R11] Slew register holds two 3-bit codes.
// [R12] Slew code doubles rate from 0.225 mV/us.
// [R13] Answer as target at address 1101000.
// [R14] All registers take reset values at start-up.
// [R15] Reserved bits ignore writes and read zero.
// [R16] Fields are static outputs, updated after write.
module rgc_regs
    import rgc_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = RGC_TARGET_ADDR // Seven-bit serial address.
) (
    input wire logic clk, // System clock, 100 MHz.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic scl_in, // Serial clock pin level.
    input wire logic sda_in, // Serial data pin level.
    output logic sda_out_q, // Serial data drive value, always low.
    output logic sda_oe_q, // Serial data output enable, high pulls the line low.
    output rgc_ctrl_t ctrl_q // Control fields for the regulator cores.
);

    // Reserved target addresses cannot be served.
    if (TARGET_ADDR < 7'h08 || TARGET_ADDR > 7'h77) begin : g_bad_addr
        $error("Target address lies in a reserved range.");
    end

    logic scl_s; // Synchronised serial clock.
    logic sda_s; // Synchronised serial data.
    logic scl_prev_q; // Serial clock one cycle earlier.
    logic sda_prev_q; // Serial data one cycle earlier.
    rgc_state_t state_q; // Serial engine state.
    logic [3:0] bit_cnt_q; // Bits moved in the current byte.
    logic [7:0] shift_q; // Receive and transmit shift register.
    logic [7:0] ptr_q; // Register pointer, advances after each data byte.
    logic rw_q; // High for a read transfer.
    logic ptr_phase_q; // High while the next received byte is the pointer.

    // Bring both pins into the clock domain.
    rgc_sync u_scl_sync (
        .clk(clk),
        .reset(reset),
        .pin_in(scl_in),
        .level_q(scl_s)
    );
    rgc_sync u_sda_sync (
        .clk(clk),
        .reset(reset),
        .pin_in(sda_in),
        .level_q(sda_s)
    );

    // Edge and bus condition decode.
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire byte_done = (bit_cnt_q == 4'h8);
    wire addr_match = (shift_q[7:1] == TARGET_ADDR); // see [R13]
    wire [7:0] ptr_next = ptr_q + 8'h01;

    // Register write strobe: a data byte completes in the receive phase.
    wire wr_stb = (state_q == RGC_ST_RX) && scl_fall && byte_done && !ptr_phase_q;
    wire wr_lin_one = wr_stb && (ptr_q == RGC_OFS_LIN_ONE); // see [R1]
    wire wr_lin_two = wr_stb && (ptr_q == RGC_OFS_LIN_TWO); // see [R1]
    wire wr_opt = wr_stb && (ptr_q == RGC_OFS_BUCK_OPT);
    wire wr_sys = wr_stb && (ptr_q == RGC_OFS_SYS_CTRL);
    wire wr_slew = wr_stb && (ptr_q == RGC_OFS_SLEW);

    // Read-back bytes; reserved bits and unmapped offsets give zero.
    wire [7:0] rd_lin_one = {2'h0, ctrl_q.linear_one_code}; // see [R15]
    wire [7:0] rd_lin_two = {2'h0, ctrl_q.linear_two_code}; // see [R15]
    wire [7:0] rd_opt = {1'b0, ctrl_q.buck_phase_select, ctrl_q.buck_two_ultrasonic,
        ctrl_q.buck_one_ultrasonic, ctrl_q.buck_two_discharge, ctrl_q.buck_one_discharge,
        ctrl_q.buck_two_auto_mode, ctrl_q.buck_one_auto_mode};
    wire [7:0] rd_sys = {1'b0, ctrl_q.bus_function_enable, ctrl_q.power_on_delay_sel,
        ctrl_q.linear_two_enable, ctrl_q.linear_one_enable, ctrl_q.buck_two_enable,
        ctrl_q.buck_one_enable};
    wire [7:0] rd_slew = {ctrl_q.buck_two_slew_code, 1'b0, ctrl_q.buck_one_slew_code, 1'b0};
    wire [7:0] rd_data = (ptr_q == RGC_OFS_LIN_ONE) ? rd_lin_one :
                         (ptr_q == RGC_OFS_LIN_TWO) ? rd_lin_two :
                         (ptr_q == RGC_OFS_BUCK_OPT) ? rd_opt :
                         (ptr_q == RGC_OFS_SYS_CTRL) ? rd_sys :
                         (ptr_q == RGC_OFS_SLEW) ? rd_slew : 8'h00;

    // Remember the previous pin levels for edge detection.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Serial target engine: sample on rising clock edges, change data on falling ones.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= RGC_ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            ptr_phase_q <= 1'b0;
            sda_out_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_seen) begin
            // A stop ends any transfer and frees the line.
            state_q <= RGC_ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_seen) begin
            // A start, repeated or not, begins an address byte.
            state_q <= RGC_ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                RGC_ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (addr_match) begin // see [R13]
                            // Acknowledge our address and note the direction bit.
                            rw_q <= shift_q[0];
                            ptr_phase_q <= ~shift_q[0];
                            sda_oe_q <= 1'b1;
                            state_q <= RGC_ST_ACK;
                        end else begin
                            state_q <= RGC_ST_IDLE;
                        end
                    end
                end
                RGC_ST_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        // Acknowledge every byte; the first one loads the pointer.
                        sda_oe_q <= 1'b1;
                        state_q <= RGC_ST_ACK;
                        ptr_phase_q <= 1'b0;
                        if (ptr_phase_q) begin
                            ptr_q <= shift_q;
                        end else begin
                            ptr_q <= ptr_next;
                        end
                    end
                end
                RGC_ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (rw_q) begin
                            // Read: present the most significant bit at once.
                            shift_q <= {rd_data[6:0], 1'b0};
                            sda_oe_q <= ~rd_data[7];
                            state_q <= RGC_ST_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= RGC_ST_RX;
                        end
                    end
                end
                RGC_ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            // Byte sent: free the line for the controller's answer.
                            sda_oe_q <= 1'b0;
                            ptr_q <= ptr_next;
                            state_q <= RGC_ST_TXACK;
                        end else begin
                            sda_oe_q <= ~shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                RGC_ST_TXACK: begin
                    if (scl_rise && sda_s) begin
                        // Not acknowledged: wait for stop or start.
                        state_q <= RGC_ST_IDLE;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        shift_q <= {rd_data[6:0], 1'b0};
                        sda_oe_q <= ~rd_data[7];
                        state_q <= RGC_ST_TX;
                    end
                end
                RGC_ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state_q <= RGC_ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Control registers; each field is a static output updated the cycle after a write.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= RGC_CTRL_RST; // see [R3] [R14]
        end else begin
            if (wr_lin_one) begin
                ctrl_q.linear_one_code <= shift_q[5:0]; // see [R1] [R2] [R15] [R16]
            end
            if (wr_lin_two) begin
                ctrl_q.linear_two_code <= shift_q[5:0]; // see [R1] [R2] [R15] [R16]
            end
            if (wr_opt) begin
                ctrl_q.buck_phase_select <= shift_q[RGC_POS_PHASE]; // see [R4]
                ctrl_q.buck_two_ultrasonic <= shift_q[RGC_POS_ULTRA_TWO]; // see [R5]
                ctrl_q.buck_one_ultrasonic <= shift_q[RGC_POS_ULTRA_ONE]; // see [R5]
                ctrl_q.buck_two_discharge <= shift_q[RGC_POS_DIS_TWO]; // see [R6]
                ctrl_q.buck_one_discharge <= shift_q[RGC_POS_DIS_ONE]; // see [R6]
                ctrl_q.buck_two_auto_mode <= shift_q[RGC_POS_AUTO_TWO]; // see [R7]
                ctrl_q.buck_one_auto_mode <= shift_q[RGC_POS_AUTO_ONE]; // see [R7]
            end
            if (wr_sys) begin
                ctrl_q.bus_function_enable <= shift_q[RGC_POS_BUS_EN]; // see [R8]
                ctrl_q.power_on_delay_sel <= shift_q[RGC_POS_POR_LO +: 2]; // see [R9]
                ctrl_q.linear_two_enable <= shift_q[RGC_POS_EN_LIN_TWO]; // see [R10]
                ctrl_q.linear_one_enable <= shift_q[RGC_POS_EN_LIN_ONE]; // see [R10]
                ctrl_q.buck_two_enable <= shift_q[RGC_POS_EN_BUCK_TWO]; // see [R10]
                ctrl_q.buck_one_enable <= shift_q[RGC_POS_EN_BUCK_ONE]; // see [R10]
            end
            if (wr_slew) begin
                ctrl_q.buck_two_slew_code <= shift_q[RGC_POS_SLEW_TWO_LO +: 3]; // see [R11] [R12]
                ctrl_q.buck_one_slew_code <= shift_q[RGC_POS_SLEW_ONE_LO +: 3]; // see [R11] [R12]
            end
        end
    end

endmodule

/* File: design/rgc_sync.sv */
`timescale 1ns/1ps

// Three-stage input synchroniser; the level moves once stages two and three agree.
module rgc_sync
    import rgc_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic pin_in, // Raw input from outside the clock domain.
    output logic level_q // Filtered, synchronised level.
);

    logic s1_q; // First stage, read only by the second stage.
    logic s2_q; // Second stage.
    logic s3_q; // Third stage.

    // Shift the pin through three stages and accept agreeing values; idle bus is high.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule

/* File: sim/regulator_control_registers_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, a, b); end end
// Drives the register bank over the serial bus and checks readback and outputs.
module regulator_control_registers_tb;
    import rgc_pkg::*;
    logic clk = 1'b0; // System clock.
    logic reset = 1'b1; // Reset, held at the start.
    wire scl; // Serial clock from the controller.
    wire sda_drv; // Controller data drive.
    logic sda_out_q; // Device data drive value.
    logic sda_oe_q; // Device data enable.
    wire sda_line = sda_drv & ~sda_oe_q; // Open-drain data line with pull-up.
    rgc_ctrl_t ctrl_q; // Control outputs.
    logic [7:0] shadow [2:6]; // Expected register contents.
    logic [7:0] d [$]; // Burst being written.
    logic [7:0] rx; // Last byte read.
    logic ack; // Last acknowledge seen.
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    rgc_regs dut_u (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .ctrl_q(ctrl_q));
    rgc_host host_u (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end
    // Keeps only the writable bits of a register.
    function automatic logic [7:0] mask(input logic [7:0] ofs, input logic [7:0] v);
        case (ofs)
            8'h02, 8'h03: return v & 8'h3F;
            8'h04, 8'h05: return v & 8'h7F;
            8'h06: return v & 8'hEE;
            default: return 8'h00;
        endcase
    endfunction
    // Builds the control fields expected from the shadow registers.
    function automatic rgc_ctrl_t exp_ctrl();
        rgc_ctrl_t c;
        c.linear_one_code = shadow[2][5:0];
        c.linear_two_code = shadow[3][5:0];
        {c.buck_phase_select, c.buck_two_ultrasonic, c.buck_one_ultrasonic,
            c.buck_two_discharge, c.buck_one_discharge, c.buck_two_auto_mode,
            c.buck_one_auto_mode} = shadow[4][6:0];
        {c.bus_function_enable, c.power_on_delay_sel, c.linear_two_enable,
            c.linear_one_enable, c.buck_two_enable, c.buck_one_enable} = shadow[5][6:0];
        c.buck_two_slew_code = shadow[6][7:5];
        c.buck_one_slew_code = shadow[6][3:1];
        return c;
    endfunction
    // Addresses the device for write and sends the pointer.
    task automatic open(input logic [7:0] ofs);
        host_u.start();
        host_u.xfer({RGC_TARGET_ADDR, 1'b0}, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        host_u.xfer(ofs, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
    endtask
    // Writes a burst from a pointer, then checks the control outputs.
    task automatic wr(input logic [7:0] ofs, input logic [7:0] q [$]);
        logic [7:0] p;
        open(ofs);
        foreach (q[i]) begin
            p = ofs + 8'(i);
            host_u.xfer(q[i], 1'b1, rx, ack);
            `CHK(ack, 1'b0)
            if (p inside {[2:6]}) shadow[p] = mask(p, q[i]);
        end
        host_u.stop();
        `CHK(ctrl_q, exp_ctrl())
    endtask
    // Reads a burst from a pointer and compares with the shadow.
    task automatic rd(input logic [7:0] ofs, input int n);
        logic [7:0] p;
        open(ofs);
        host_u.start();
        host_u.xfer({RGC_TARGET_ADDR, 1'b1}, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        for (int i = 0; i < n; i++) begin
            p = ofs + 8'(i);
            host_u.xfer(8'hFF, (i == n - 1), rx, ack);
            `CHK(rx, (p inside {[2:6]}) ? shadow[p] : 8'h00)
        end
        host_u.stop();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    // Main sequence.
    initial begin
        shadow = '{8'h0C, 8'h0C, 8'h0F, 8'h2F, 8'h22};
        void'($urandom(32'hBA7FFE65));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(ctrl_q, exp_ctrl())
        rd(8'h02, 5);
        // All ones, all zeros, then random bursts over the whole map.
        for (int r = 0; r < 6; r++) begin
            d = '{};
            for (int k = 0; k < 5; k++) d.push_back(r == 0 ? 8'hFF : r == 1 ? 8'h00 : 8'($urandom));
            wr(8'h02, d);
            rd(8'h02, 5);
        end
        // Every delay and slew code, and the bus enable both ways.
        for (int c = 0; c < 8; c++) begin
            wr(8'h05, '{8'(c << 4), 8'(c * 8'h22)});
            rd(8'h05, 3);
        end
        wr(8'h02, '{8'h36, 8'h37});
        rd(8'h02, 2);
        // A read with no pointer byte continues where the last read stopped.
        host_u.start();
        host_u.xfer({RGC_TARGET_ADDR, 1'b1}, 1'b1, rx, ack);
        `CHK(ack, 1'b0)
        host_u.xfer(8'hFF, 1'b1, rx, ack);
        `CHK(rx, shadow[4])
        host_u.stop();
        // Unmapped pointers are acknowledged, ignored and read as zero.
        wr(8'h00, '{8'hA5, 8'h5A});
        wr(8'h07, '{8'h3C});
        rd(8'h00, 2);
        rd(8'h07, 1);
        // Another address gets no acknowledge.
        host_u.start();
        host_u.xfer({7'h69, 1'b0}, 1'b1, rx, ack);
        `CHK(ack, 1'b1)
        host_u.stop();
        // Reset in mid-run restores every register.
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        shadow = '{8'h0C, 8'h0C, 8'h0F, 8'h2F, 8'h22};
        repeat (6) @(posedge clk);
        `CHK(ctrl_q, exp_ctrl())
        rd(8'h02, 5);
        wrap_up();
    end
endmodule

/* File: sim/rgc_host.sv */
`timescale 1ns/1ps
// Serial bus controller; the clock idles high between frames, data is open drain.
module rgc_host (
    input wire logic clk, // System clock that paces the bits.
    output logic scl, // Serial clock from the controller.
    output logic sda_drv, // Data release (1) or pull low (0).
    input wire logic sda_line // Resolved data line level.
);
    // Both lines start released, so the pull-up holds them high.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Waits a number of system clocks.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        tick(1);
        scl <= 1'b0;
        tick(4);
        sda_drv <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_drv <= 1'b0;
        tick(8);
    endtask
    // Stop: data rises while the clock is high, then the bus rests.
    task automatic stop();
        tick(1);
        scl <= 1'b0;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_drv <= 1'b1;
        tick(8);
    endtask
    // Moves eight bits MSB first plus the acknowledge, 16 clocks per bit.
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack_out);
        logic [8:0] bits;
        logic [8:0] got;
        bits = {tx, ack_in};
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            scl <= 1'b0;
            tick(4);
            sda_drv <= bits[i];
            tick(4);
            scl <= 1'b1;
            tick(4);
            got[i] = sda_line;
            tick(3);
        end
        rx = got[8:1];
        ack_out = got[0];
    endtask
endmodule

/* File: sim/rgc_regs_chk.sv */
`timescale 1ns/1ps
// Watches the serial pins and the control outputs of the register bank.
module rgc_chk
    import rgc_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = RGC_TARGET_ADDR // Address that must be acknowledged.
) (
    input wire logic clk, // System clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic scl_in, // Serial clock level.
    input wire logic sda_in, // Serial data level.
    input wire logic sda_out_q, // Data drive value.
    input wire logic sda_oe_q, // Data output enable.
    input rgc_ctrl_t ctrl_q // Control fields.
);
    logic [3:0] rise_q; // Clock rises since the last start, parked at 15.
    logic [7:0] shift_q; // Bits gathered since the last start.
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Counts bits after a start so the address byte can be judged.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rise_q <= 4'hF;
            shift_q <= 8'h00;
        end else if (scl_in && $fell(sda_in)) begin
            rise_q <= 4'h0;
        end else if ($rose(scl_in) && rise_q != 4'hF) begin
            rise_q <= rise_q + 4'h1;
            shift_q <= {shift_q[6:0], sda_in};
        end
    end
    drive_low_a: assert property (!sda_out_q)
        else $error("Data drive value is not low.");
    reset_val_a: assert property ($past(reset) |-> ctrl_q == RGC_CTRL_RST && !sda_oe_q)
        else $error("Outputs are not at reset values after reset.");
    // A register write lands on the same edge that starts the acknowledge drive.
    ctrl_ack_a: assert property (!$stable(ctrl_q) |-> sda_oe_q)
        else $error("Control fields changed outside a write.");
    ctrl_quiet_a: assert property (scl_in && $past(scl_in) |-> $stable(ctrl_q))
        else $error("Control fields changed while the clock was high.");
    oe_quiet_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_q))
        else $error("Data drive changed while the clock was high.");
    oe_hold_a: assert property ($rose(sda_oe_q) |=> sda_oe_q [*8])
        else $error("Data drive was too short.");
    addr_quiet_a: assert property (rise_q < 4'h8 |-> !sda_oe_q)
        else $error("Data driven during the address byte.");
    addr_ack_a: assert property ($rose(scl_in) && rise_q == 4'h8 |->
        sda_oe_q == (shift_q[7:1] == TARGET_ADDR))
        else $error("Address acknowledge is wrong.");
endmodule

bind rgc_regs rgc_chk #(.TARGET_ADDR(TARGET_ADDR)) chk_u (.clk(clk), .reset(reset),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .ctrl_q(ctrl_q));
